// File: rtl/irac_adc_divider.sv
// Scaled ADC clock enable generator for infrared ambient conversions.
`timescale 1ns/1ps
module irac_adc_divider (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Control
	input wire logic [2:0] scale,
	input wire logic run,
	// Divided enable pulse
	output logic adc_tick
);
	localparam logic [3:0] BASE_LAST = 4'(irac_pkg::IRAC_ADC_DIV_CYCLES - 1);
	logic [3:0] base_reg;
	logic base_tick;
	logic [6:0] scale_reg;
	logic [6:0] scale_last;

	// Largest count of the scale divider, two to the scale minus one.
	assign scale_last = 7'((8'h01 << scale) - 8'h01);
	assign base_tick = (base_reg == BASE_LAST);

	// Base ADC clock enable, one pulse each ADC clock period.
	always_ff @(posedge clock) begin
		if (srst || !run || base_tick) begin
			base_reg <= 4'h0;
		end else begin
			base_reg <= base_reg + 4'h1;
		end
	end

	// Power-of-two divider; restarts when idle so each conversion sees full periods.
	always_ff @(posedge clock) begin
		if (srst || !run) begin
			scale_reg <= 7'h00;
			adc_tick <= 1'b0;
		end else begin
			adc_tick <= 1'b0;
			if (base_tick) begin
				if (scale_reg >= scale_last) begin
					scale_reg <= 7'h00;
					adc_tick <= 1'b1;
				end else begin
					scale_reg <= scale_reg + 7'h01;
				end
			end
		end
	end
endmodule

// File: rtl/irac_pkg.sv
// Package of register offsets, fields, reset values and timing counts for the IR ambient slice.
package irac_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] IRAC_SCALE_OFFSET = 8'h1e;
	localparam logic [7:0] IRAC_RANGE_OFFSET = 8'h1f;
	localparam logic [7:0] IRAC_STATUS_OFFSET = 8'h20;
	localparam logic [7:0] IRAC_MASK_OFFSET = 8'h21;
	localparam logic [7:0] IRAC_CTRL_OFFSET = 8'h22;
	// ****************************************
	// Fields and reset values
	// ****************************************
	localparam int IRAC_SCALE_MSB = 2;
	localparam logic [2:0] IRAC_SCALE_MAX = 3'h7;
	localparam logic [2:0] IRAC_SCALE_RESET = 3'h0;
	localparam int IRAC_RANGE_BIT = 5;
	localparam logic [4:0] IRAC_RANGE_RSVD_RESET = 5'h00;
	localparam logic [7:0] IRAC_RANGE_RESET = 8'h00;
	localparam logic [7:0] IRAC_MASK_RESET = 8'h00;
	// Status bits: 0 conversion done, 1 scale changed, 2 range changed.
	localparam int IRAC_EV_DONE = 0;
	localparam int IRAC_EV_SCALE = 1;
	localparam int IRAC_EV_RANGE = 2;
	localparam int IRAC_EV_W = 3;
	// Base conversion length in divided ADC clock ticks.
	localparam logic [7:0] IRAC_CONV_TICKS = 8'h10;
	// Gain reduction in high range, as 14.5 scaled by two.
	localparam logic [4:0] IRAC_HIGH_RANGE_DIV_X2 = 5'h1d;
	// Base ADC clock period 50 ns against the 8 ns system clock, rounded down.
	localparam int IRAC_ADC_PERIOD_NS = 50;
	localparam int IRAC_CLK_PERIOD_NS = 8;
	localparam int IRAC_ADC_DIV_CYCLES = IRAC_ADC_PERIOD_NS / IRAC_CLK_PERIOD_NS;
endpackage

// File: rtl/irac_top.sv
// Top of the infrared ambient ADC configuration slice with register port and interrupt pin.
`timescale 1ns/1ps
// Function
// - A three-bit scale lengthens IR ambient integration by two to the scale, 128 at most.
// - The ADC clock for IR ambient conversions is divided by two to the scale.
// - The range bit selects normal gain at zero and gain reduced by 14.5 at one.
// - The interrupt pin is open drain: only pulled low, never driven high.
module irac_top (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	// Conversion control toward the measurement path
	input wire logic conv_start,
	output logic conv_busy,
	output logic high_range_active,
	output logic [4:0] gain_div_x2,
	// Interrupt pin, open drain
	input wire logic int_pin_in,
	output logic int_pin_out,
	output logic int_pin_oe
);
	// ****************************************
	// State and declarations
	// ****************************************
	typedef enum logic [1:0] {
		IRAC_IDLE = 2'b01,
		IRAC_CONV = 2'b10
	} irac_state_t;

	// Sequencer and parameter state.
	irac_state_t state_reg;
	logic [2:0] scale_reg;
	logic [4:0] range_rsvd_reg;
	logic range_reg;
	logic [7:0] mask_reg;
	// Interrupt flags and their next value.
	logic [2:0] status_reg;
	logic [2:0] ev_set;
	logic [2:0] status_next;
	// Conversion tick count and its end point.
	logic [15:0] tick_reg;
	logic [15:0] ticks_needed;
	logic adc_tick;
	// Pin synchroniser, interrupt request and decoded strobes.
	logic int_sync1_reg;
	logic int_sync2_reg;
	logic irq_next;
	logic wr_scale;
	logic wr_range;
	logic [7:0] range_read;

	// Register decode, used by both the write and read paths.
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
		hit = (addr == off);
	endfunction

	// Decoded write strobes and the range readback word.
	assign wr_scale = reg_write && hit(reg_addr, irac_pkg::IRAC_SCALE_OFFSET);
	assign wr_range = reg_write && hit(reg_addr, irac_pkg::IRAC_RANGE_OFFSET);
	assign range_read = {2'b00, range_reg, range_rsvd_reg};

	// ****************************************
	// Parameter registers
	// ****************************************

	// Scale parameter: only bits 2:0 are stored, upper bits dropped.
	always_ff @(posedge clock) begin
		if (srst) begin
			scale_reg <= irac_pkg::IRAC_SCALE_RESET;
		end else if (wr_scale) begin
			scale_reg <= reg_wdata[irac_pkg::IRAC_SCALE_MSB:0];
		end
	end

	// Range parameter; reserved bits simply hold whatever the host writes back.
	always_ff @(posedge clock) begin
		if (srst) begin
			range_reg <= 1'b0;
			range_rsvd_reg <= irac_pkg::IRAC_RANGE_RSVD_RESET;
		end else if (wr_range) begin
			range_reg <= reg_wdata[irac_pkg::IRAC_RANGE_BIT];
			range_rsvd_reg <= reg_wdata[4:0];
		end
	end

	// Mask register, same layout as status.
	always_ff @(posedge clock) begin
		if (srst) begin
			mask_reg <= irac_pkg::IRAC_MASK_RESET;
		end else if (reg_write && hit(reg_addr, irac_pkg::IRAC_MASK_OFFSET)) begin
			mask_reg <= reg_wdata;
		end
	end

	// ****************************************
	// Conversion sequencing
	// ****************************************
	// Divided ADC tick; the divider restarts while the sequencer is idle.
	irac_adc_divider u_div (
		.clock(clock),
		.srst(srst),
		.scale(scale_reg),
		.run(state_reg == IRAC_CONV),
		.adc_tick(adc_tick)
	);

	// Integration spans a fixed count of divided ticks, so time grows by two to the scale.
	// Only the power-of-two stretch is fixed; the base tick count is a house choice.
	assign ticks_needed = {8'h00, irac_pkg::IRAC_CONV_TICKS};

	// Conversion state machine; a start during a conversion is ignored.
	always_ff @(posedge clock) begin
		if (srst) begin
			state_reg <= IRAC_IDLE;
			tick_reg <= 16'h0000;
		end else begin
			unique case (state_reg)
				IRAC_IDLE: begin
					tick_reg <= 16'h0000;
					if (conv_start) begin
						state_reg <= IRAC_CONV;
					end
				end
				IRAC_CONV: begin
					if (adc_tick) begin
						if (tick_reg == ticks_needed - 16'h0001) begin
							state_reg <= IRAC_IDLE;
						end
						tick_reg <= tick_reg + 16'h0001;
					end
				end
				default: begin
					state_reg <= IRAC_IDLE;
				end
			endcase
		end
	end

	// Outputs toward the analog path, registered.
	always_ff @(posedge clock) begin
		if (srst) begin
			conv_busy <= 1'b0;
			high_range_active <= 1'b0;
			gain_div_x2 <= 5'h02;
		end else begin
			conv_busy <= (state_reg == IRAC_CONV);
			high_range_active <= range_reg;
			gain_div_x2 <= range_reg ? irac_pkg::IRAC_HIGH_RANGE_DIV_X2 : 5'h02;
		end
	end

	// ****************************************
	// Interrupts
	// ****************************************
	// Events: conversion done, scale written, range written.
	assign ev_set[irac_pkg::IRAC_EV_DONE] = (state_reg == IRAC_CONV) && adc_tick
		&& (tick_reg == ticks_needed - 16'h0001);
	assign ev_set[irac_pkg::IRAC_EV_SCALE] = wr_scale;
	assign ev_set[irac_pkg::IRAC_EV_RANGE] = wr_range;

	// Status clears on read, but a new event in the same cycle wins.
	always_comb begin
		status_next = status_reg;
		if (reg_read && hit(reg_addr, irac_pkg::IRAC_STATUS_OFFSET)) begin
			status_next = 3'h0;
		end
		status_next = status_next | ev_set;
	end

	// Sticky status flags.
	always_ff @(posedge clock) begin
		if (srst) begin
			status_reg <= 3'h0;
		end else begin
			status_reg <= status_next;
		end
	end

	// Level request from any unmasked flag, taken from the next value to save a cycle.
	assign irq_next = |(status_next & mask_reg[2:0]);

	// The pin is only ever pulled low: data is tied low and enable carries the request.
	always_ff @(posedge clock) begin
		if (srst) begin
			int_pin_oe <= 1'b0;
			int_pin_out <= 1'b0;
		end else begin
			int_pin_oe <= irq_next;
			int_pin_out <= 1'b0;
		end
	end

	// Pin level readback through two flops; lets software see the line held low elsewhere.
	always_ff @(posedge clock) begin
		if (srst) begin
			int_sync1_reg <= 1'b1;
			int_sync2_reg <= 1'b1;
		end else begin
			int_sync1_reg <= int_pin_in;
			int_sync2_reg <= int_sync1_reg;
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	// Read data stand one cycle; idle cycles return zero so that a late sample shows.
	always_ff @(posedge clock) begin
		if (srst) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			if (hit(reg_addr, irac_pkg::IRAC_SCALE_OFFSET)) begin
				reg_rdata <= {5'h00, scale_reg};
			end else if (hit(reg_addr, irac_pkg::IRAC_RANGE_OFFSET)) begin
				reg_rdata <= range_read;
			end else if (hit(reg_addr, irac_pkg::IRAC_STATUS_OFFSET)) begin
				reg_rdata <= {5'h00, status_reg};
			end else if (hit(reg_addr, irac_pkg::IRAC_MASK_OFFSET)) begin
				reg_rdata <= mask_reg;
			end else if (hit(reg_addr, irac_pkg::IRAC_CTRL_OFFSET)) begin
				reg_rdata <= {6'h00, int_sync2_reg, conv_busy};
			end else begin
				reg_rdata <= 8'h00;
			end
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	// Every check sleeps during reset except the scale reset check, which spans the release.

	// Scale parameter storage and readback.
	scale_reset_a: assert property (@(posedge clock) srst |=> scale_reg == 3'h0)
		else $error("scale not zero after reset");
	scale_read_a: assert property (@(posedge clock) disable iff (srst)
		reg_read && reg_addr == irac_pkg::IRAC_SCALE_OFFSET |=> reg_rdata[7:3] == 5'h00)
		else $error("scale upper bits not zero");
	scale_store_a: assert property (@(posedge clock) disable iff (srst)
		wr_scale |=> scale_reg == $past(reg_wdata[2:0]))
		else $error("scale write lost");
	// The scale may only move on a write, or the conversion length would drift.
	scale_hold_a: assert property (@(posedge clock) disable iff (srst)
		!wr_scale |=> scale_reg == $past(scale_reg))
		else $error("scale changed without a write");

	// Range selection and reserved bits.
	range_gain_a: assert property (@(posedge clock) disable iff (srst)
		wr_range && reg_wdata[5] |=> ##1 gain_div_x2 == 5'h1d)
		else $error("high range gain wrong");
	gain_normal_a: assert property (@(posedge clock) disable iff (srst)
		!range_reg |=> gain_div_x2 == 5'h02)
		else $error("normal range gain wrong");
	range_flag_a: assert property (@(posedge clock) disable iff (srst)
		wr_range |=> ##1 high_range_active == $past(reg_wdata[5], 2))
		else $error("range flag wrong");
	// The host leaves one idle cycle between its write-back and the check read.
	range_keep_a: assert property (@(posedge clock) disable iff (srst)
		wr_range ##1 !reg_write ##1 reg_read && reg_addr == irac_pkg::IRAC_RANGE_OFFSET
		|=> reg_rdata[4:0] == $past(reg_wdata[4:0], 3))
		else $error("range reserved bits not kept");

	// Open-drain pin and sticky status.
	int_drain_a: assert property (@(posedge clock) disable iff (srst)
		int_pin_out == 1'b0)
		else $error("interrupt pin driven high");
	irq_raise_a: assert property (@(posedge clock) disable iff (srst)
		wr_scale && mask_reg[irac_pkg::IRAC_EV_SCALE] |=> int_pin_oe)
		else $error("unmasked event did not pull the pin");
	irq_mask_a: assert property (@(posedge clock) disable iff (srst)
		mask_reg[2:0] == 3'h0 |=> !int_pin_oe)
		else $error("masked events pulled the pin");
	status_keep_a: assert property (@(posedge clock) disable iff (srst)
		status_reg[irac_pkg::IRAC_EV_DONE] && !reg_read |=> status_reg[irac_pkg::IRAC_EV_DONE])
		else $error("done flag lost without a read");
	status_clear_a: assert property (@(posedge clock) disable iff (srst)
		reg_read && reg_addr == irac_pkg::IRAC_STATUS_OFFSET && ev_set == 3'h0
		|=> status_reg == 3'h0 && !int_pin_oe)
		else $error("status read did not release the pin");

	// Conversion length against the scale.
	conv_begin_a: assert property (@(posedge clock) disable iff (srst)
		conv_start && state_reg == IRAC_IDLE |=> ##1 conv_busy)
		else $error("conversion did not start");
	conv_short_a: assert property (@(posedge clock) disable iff (srst)
		$rose(conv_busy) && scale_reg == 3'h0 |-> ##[1:200] !conv_busy)
		else $error("undivided conversion too long");
	// At scale one a conversion lasts twice the undivided one, so busy outlasts 100 cycles.
	conv_min_a: assert property (@(posedge clock) disable iff (srst)
		$rose(conv_busy) && scale_reg == 3'h1 && !wr_scale |-> ##100 conv_busy)
		else $error("divided conversion too short");
endmodule

// File: tb/irac_host_line.sv
// Host side model of the open-drain interrupt wire with its pull-up resistor.
`timescale 1ns/1ps
module irac_host_line (
	// Device pin drive
	input wire logic int_pin_out,
	input wire logic int_pin_oe,
	// Resolved wire level
	output logic int_wire
);
	// The host never drives this line; only the pull-up holds it high, also during power-up.
	assign int_wire = int_pin_oe ? int_pin_out : 1'b1;
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the infrared ambient configuration slice.
`timescale 1ns/1ps
module tb_top;
	// ****************************************
	// Signals and instances
	// ****************************************
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic conv_start = 1'b0;
	logic [7:0] reg_rdata;
	logic conv_busy;
	logic high_range_active;
	logic [4:0] gain_div_x2;
	logic int_pin_out;
	logic int_pin_oe;
	logic int_wire;
	logic [7:0] rv;
	logic [7:0] d;
	int bad_count = 0;
	int comparisons = 0;
	int seed = 14015;
	int n;
	int lim;
	int s_list[5] = '{0, 1, 4, 6, 7};
	// Free-running 125 MHz clock.
	always #4 clock = ~clock;
	irac_top dut (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.conv_start(conv_start), .conv_busy(conv_busy), .high_range_active(high_range_active),
		.gain_div_x2(gain_div_x2), .int_pin_in(int_wire), .int_pin_out(int_pin_out),
		.int_pin_oe(int_pin_oe));
	irac_host_line host (.int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe), .int_wire(int_wire));
	// ****************************************
	// Tasks and expectation functions
	// ****************************************
	// Prints the counts and the verdict, then stops the run.
	task automatic give_verdict();
		$display("mismatches %0d comparisons %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_span(input int got, input int lo, input int hi);
		comparisons++;
		if (got < lo || got > hi) begin
			bad_count++;
			$display("unexpected at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so they are sampled there.
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 v = reg_rdata;
	endtask
	function automatic logic [7:0] exp_gain(input logic hi);
		return hi ? 8'h1d : 8'h02;
	endfunction
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		rd(irac_pkg::IRAC_SCALE_OFFSET, rv); chk_val(rv, 8'h00);
		chk_val({3'h0, gain_div_x2}, 8'h02);
		chk_val({7'h00, int_pin_oe}, 8'h00);
		// Every scale value with random reserved bits, then a random range value.
		for (int i = 0; i < 8; i++) begin
			d = 8'($random(seed));
			wr(irac_pkg::IRAC_SCALE_OFFSET, {d[7:3], i[2:0]});
			rd(irac_pkg::IRAC_SCALE_OFFSET, rv); chk_val(rv, {5'h00, i[2:0]});
			wr(irac_pkg::IRAC_RANGE_OFFSET, d);
			rd(irac_pkg::IRAC_RANGE_OFFSET, rv); chk_val(rv, {2'h0, d[5:0]});
			chk_val({3'h0, gain_div_x2}, exp_gain(d[5]));
			chk_val({7'h00, high_range_active}, {7'h00, d[5]});
		end
		// Host flips only the range bit and keeps the reserved low bits.
		rd(irac_pkg::IRAC_RANGE_OFFSET, rv);
		wr(irac_pkg::IRAC_RANGE_OFFSET, rv ^ 8'h20);
		rd(irac_pkg::IRAC_RANGE_OFFSET, d); chk_val(d, rv ^ 8'h20);
		chk_val({3'h0, gain_div_x2}, exp_gain(d[5]));
		// Unmapped place: writes vanish and reads give zero.
		wr(8'h40, 8'hff);
		rd(8'h40, rv); chk_val(rv, 8'h00);
		// Conversion length grows by two to the scale; one divided tick of phase slack.
		foreach (s_list[k]) begin
			wr(irac_pkg::IRAC_SCALE_OFFSET, s_list[k][7:0]);
			@(posedge clock);
			conv_start <= 1'b1;
			@(posedge clock);
			conv_start <= 1'b0;
			n = 0;
			lim = 20000;
			// Busy rises one edge after the start is taken, so wait for it before counting.
			while (conv_busy !== 1'b1 && lim > 0) begin
				@(posedge clock);
				#1;
				lim--;
			end
			while (conv_busy !== 1'b0 && lim > 0) begin
				@(posedge clock);
				#1;
				n++;
				lim--;
			end
			if (lim == 0) begin
				bad_count++;
				give_verdict();
			end
			lim = 16 * irac_pkg::IRAC_ADC_DIV_CYCLES << s_list[k];
			chk_span(n, lim - (irac_pkg::IRAC_ADC_DIV_CYCLES << s_list[k]),
				lim + (irac_pkg::IRAC_ADC_DIV_CYCLES << s_list[k]) + 2);
		end
		// Interrupt: unmasked event pulls the wire low, a status read releases it.
		rd(irac_pkg::IRAC_STATUS_OFFSET, rv); chk_val(rv, 8'h07);
		wr(irac_pkg::IRAC_MASK_OFFSET, 8'h07);
		rd(irac_pkg::IRAC_CTRL_OFFSET, rv); chk_val(rv, 8'h02);
		wr(irac_pkg::IRAC_SCALE_OFFSET, 8'h03);
		@(posedge clock);
		#1 chk_val({6'h00, int_pin_oe, int_pin_out}, 8'h02);
		chk_val({7'h00, int_wire}, 8'h00);
		rd(irac_pkg::IRAC_CTRL_OFFSET, rv); chk_val(rv, 8'h00);
		rd(irac_pkg::IRAC_STATUS_OFFSET, rv); chk_val(rv, 8'h02);
		@(posedge clock);
		#1 chk_val({7'h00, int_wire}, 8'h01);
		// Masked event stays sticky but leaves the wire alone.
		wr(irac_pkg::IRAC_MASK_OFFSET, 8'h00);
		rd(irac_pkg::IRAC_RANGE_OFFSET, d);
		wr(irac_pkg::IRAC_RANGE_OFFSET, d | 8'h20);
		@(posedge clock);
		#1 chk_val({7'h00, int_pin_oe}, 8'h00);
		rd(irac_pkg::IRAC_STATUS_OFFSET, rv); chk_val(rv, 8'h04);
		give_verdict();
	end
endmodule
